// >>> src/scb_pkg.sv
package scb_pkg;
  localparam logic [5:0] ADDR_ID = 6'h00;
  localparam logic [5:0] ADDR_EN = 6'h01;
  localparam logic [5:0] ADDR_DRV = 6'h02;
  localparam logic [5:0] ADDR_REF = 6'h03;
  localparam logic [5:0] ADDR_PRE = 6'h04;
  localparam logic [5:0] ADDR_PFD = 6'h05;
  localparam logic [5:0] ADDR_DEL = 6'h06;
  // Arbitrary neutral identity value
  localparam logic [23:0] ID_WORD = 24'h00A5C3;
  localparam logic [15:0] RST_EN = 16'hFE9B;
  localparam logic [1:0] RST_DRV = 2'h3;
  localparam logic [16:0] RST_REF = 17'h08001;
  localparam logic RST_PRE = 1'b0;
  localparam logic [2:0] RST_PFD = 3'h6;
  localparam logic [2:0] RST_DEL = 3'h2;
  localparam int STB_REGS = 0;
  localparam int STB_DIG = 1;
  localparam int STB_TEMP = 3;
  localparam int EN_BIAS = 1;
  localparam int EN_DIV = 2;
  localparam int EN_SQBUF = 7;
  localparam int EN_SINBUF = 8;
  localparam int EN_VCOCLK = 9;
  localparam int EN_LKD = 11;
  localparam int EN_PUMP = 12;
  localparam int EN_DSM = 13;
  localparam int EN_LOCK = 14;
  localparam int EN_SLIP = 15;
  localparam int DRV_VAL = 0;
  localparam int DRV_FORCE = 1;
  localparam int REF_SEL = 14;
  localparam int REF_AUTO = 15;
  localparam int REF_SIN = 16;
  localparam logic [13:0] RATIO_ONE = 14'h0001;
  localparam logic [4:0] LAST_BIT = 5'h1F;
  localparam logic [4:0] ADDR_DONE = 5'h06;
  typedef enum logic [1:0] {
    SCB_IDLE = 2'b00,
    SCB_SHIFT = 2'b01,
    SCB_DONE = 2'b10
  } scb_state_t;
endpackage

// >>> src/scb_synth_control_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
module scb_synth_control_register_bank (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sclk_pin,
  input wire logic sen_pin,
  input wire logic sdi_pin,
  input wire logic lock_status,
  output logic lock_or_readback_pin_o,
  output logic lock_or_readback_pin_oe,
  output logic [15:0] block_enable_and_reset,
  output logic [13:0] ref_div_ratio,
  output logic ref_div_run,
  output logic ref_div_bypass,
  output logic sine_ref_select,
  output logic square_buffer_on,
  output logic sine_buffer_on,
  output logic prescaler_long_low,
  output logic pfd_invert,
  output logic pfd_up_pass,
  output logic pfd_dn_pass,
  output logic [2:0] pfd_delay,
  output logic pump_enable,
  output logic loop_enable,
  output logic dsm_clk_from_vco,
  output logic dsm_rst_n,
  output logic lock_det_rst_n,
  output logic slip_prevention_rst_n,
  output logic lock_gate_en,
  output logic soft_reset_dig,
  output logic temp_measure_start
);
  import scb_pkg::*;

  logic [2:0] sclk_s1_q, sclk_s2_q;
  logic sclk_prev_q;
  logic [15:0] en_q;
  logic [1:0] drv_q;
  logic [16:0] ref_q;
  logic pre_q;
  logic [2:0] pfd_q, del_q;
  scb_state_t state_q;
  logic [4:0] cnt_q;
  logic rd_q;
  logic [5:0] addr_q;
  logic [23:0] sh_q;
  logic [23:0] rd_sh_q;
  logic sdo_q;
  logic rd_active_q;
  logic clear_regs;
  logic wr_done;
  logic [23:0] wdata;
  logic rise, fall, sen, sdi;

  // Serial pins through two-flop synchronisers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s1_q <= 3'h0;
      sclk_s2_q <= 3'h0;
    end else begin
      sclk_s1_q <= {sclk_pin, sen_pin, sdi_pin};
      sclk_s2_q <= sclk_s1_q;
    end
  end

  // Edge detection on synchronised clock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s2_q[2];
    end
  end

  assign sen = sclk_s2_q[1];
  assign sdi = sclk_s2_q[0];
  assign rise = sclk_s2_q[2] & ~sclk_prev_q;
  assign fall = ~sclk_s2_q[2] & sclk_prev_q;
  assign wdata = sh_q; // Rises 8 to 31 carry the data; rise 32 only closes the frame
  assign wr_done = rise && sen && (state_q == SCB_SHIFT) && (cnt_q == LAST_BIT) && !rd_q;
  assign clear_regs = wr_done && (addr_q == ADDR_ID) && wdata[STB_REGS];

  // Frame sequencing: flag, address, data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SCB_IDLE;
      cnt_q <= 5'h00;
      rd_q <= 1'b0;
      addr_q <= 6'h00;
      sh_q <= 24'h000000;
    end else if (!sen) begin
      state_q <= SCB_IDLE;
      cnt_q <= 5'h00;
    end else if (rise) begin
      case (state_q)
        SCB_IDLE: begin
          rd_q <= sdi;
          cnt_q <= 5'h01;
          state_q <= SCB_SHIFT;
        end
        SCB_SHIFT: begin
          if (cnt_q <= ADDR_DONE) begin
            addr_q <= {addr_q[4:0], sdi};
          end else if (cnt_q != LAST_BIT) begin
            sh_q <= {sh_q[22:0], sdi};
          end
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == LAST_BIT) begin
            state_q <= SCB_DONE;
          end
        end
        default: begin
          state_q <= SCB_DONE;
        end
      endcase
    end
  end

  // Read data selection
  function automatic logic [23:0] rd_word(input logic [5:0] a, input logic [15:0] e,
                                          input logic [1:0] d, input logic [16:0] r,
                                          input logic p, input logic [2:0] f,
                                          input logic [2:0] l);
    if (a == ADDR_ID) rd_word = ID_WORD;
    else if (a == ADDR_EN) rd_word = {8'h00, e};
    else if (a == ADDR_DRV) rd_word = {22'h0, d};
    else if (a == ADDR_REF) rd_word = {7'h0, r};
    else if (a == ADDR_PRE) rd_word = {23'h0, p};
    else if (a == ADDR_PFD) rd_word = {21'h0, f};
    else if (a == ADDR_DEL) rd_word = {21'h0, l};
    else rd_word = 24'h000000;
  endfunction

  // Read shifter, MSB first, launched on rising edges
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_sh_q <= 24'h000000;
      rd_active_q <= 1'b0;
    end else if (!sen) begin
      rd_active_q <= 1'b0;
    end else if (rise && state_q == SCB_SHIFT && rd_q) begin
      if (cnt_q == ADDR_DONE) begin
        rd_sh_q <= rd_word({addr_q[4:0], sdi}, en_q, drv_q, ref_q, pre_q, pfd_q, del_q);
        rd_active_q <= 1'b1;
      end else if (cnt_q != ADDR_DONE + 5'h01) begin
        rd_sh_q <= {rd_sh_q[22:0], 1'b0}; // MSB stays through rise 8
      end
    end else if (fall && state_q == SCB_DONE) begin
      rd_active_q <= 1'b0;
    end
  end

  // Pin output: read data during reads, lock status otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= rd_active_q ? rd_sh_q[23] : lock_status;
    end
  end
  assign lock_or_readback_pin_o = sdo_q;

  // Driver enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock_or_readback_pin_oe <= 1'b0;
    end else if (drv_q[DRV_FORCE]) begin
      lock_or_readback_pin_oe <= drv_q[DRV_VAL];
    end else begin
      lock_or_readback_pin_oe <= rd_active_q;
    end
  end

  // Register writes and soft register reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= RST_EN;
      drv_q <= RST_DRV;
      ref_q <= RST_REF;
      pre_q <= RST_PRE;
      pfd_q <= RST_PFD;
      del_q <= RST_DEL;
    end else if (clear_regs) begin
      en_q <= RST_EN;
      drv_q <= RST_DRV;
      ref_q <= RST_REF;
      pre_q <= RST_PRE;
      pfd_q <= RST_PFD;
      del_q <= RST_DEL;
    end else if (wr_done) begin
      if (addr_q == ADDR_EN) en_q <= wdata[15:0];
      else if (addr_q == ADDR_DRV) drv_q <= wdata[1:0];
      else if (addr_q == ADDR_REF) ref_q <= wdata[16:0];
      else if (addr_q == ADDR_PRE) pre_q <= wdata[0];
      else if (addr_q == ADDR_PFD) pfd_q <= wdata[2:0];
      else if (addr_q == ADDR_DEL) del_q <= wdata[2:0];
    end
  end

  // Strobes: one-cycle pulses, never stored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_dig <= 1'b0;
      temp_measure_start <= 1'b0;
    end else begin
      soft_reset_dig <= wr_done && addr_q == ADDR_ID && wdata[STB_DIG];
      temp_measure_start <= wr_done && addr_q == ADDR_ID && wdata[STB_TEMP];
    end
  end

  // Registered copy of the enable register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      block_enable_and_reset <= RST_EN;
    end else begin
      block_enable_and_reset <= en_q;
    end
  end

  // Reference divider ratio
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_div_ratio <= RST_REF[13:0];
    end else begin
      ref_div_ratio <= ref_q[13:0];
    end
  end

  // Reference divider run, low holds it in reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_div_run <= 1'b0;
    end else begin
      ref_div_run <= en_q[EN_DIV];
    end
  end

  // Divider bypass: held divider, auto mode or manual select
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_div_bypass <= 1'b1;
    end else if (!en_q[EN_DIV]) begin
      ref_div_bypass <= 1'b1;
    end else if (ref_q[REF_AUTO]) begin
      ref_div_bypass <= (ref_q[13:0] == RATIO_ONE);
    end else begin
      ref_div_bypass <= !ref_q[REF_SEL];
    end
  end

  // Sine or square reference select
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sine_ref_select <= 1'b0;
    end else begin
      sine_ref_select <= ref_q[REF_SIN];
    end
  end

  // Square buffer, gated so it never fights the sine select
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      square_buffer_on <= 1'b0;
    end else begin
      square_buffer_on <= en_q[EN_SQBUF] && !ref_q[REF_SIN];
    end
  end

  // Sine buffer, only with sine select set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sine_buffer_on <= 1'b0;
    end else begin
      sine_buffer_on <= en_q[EN_SINBUF] && ref_q[REF_SIN];
    end
  end

  // Prescaler long low time
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prescaler_long_low <= 1'b0;
    end else begin
      prescaler_long_low <= pre_q;
    end
  end

  // Detector polarity
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pfd_invert <= 1'b0;
    end else begin
      pfd_invert <= pfd_q[0];
    end
  end

  // Up pulse pass to pump
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pfd_up_pass <= 1'b0;
    end else begin
      pfd_up_pass <= pfd_q[1];
    end
  end

  // Down pulse pass to pump
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pfd_dn_pass <= 1'b0;
    end else begin
      pfd_dn_pass <= pfd_q[2];
    end
  end

  // Detector delay setpoint
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pfd_delay <= RST_DEL;
    end else begin
      pfd_delay <= del_q;
    end
  end

  // Charge pump, also off with the loop disabled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pump_enable <= 1'b0;
    end else begin
      pump_enable <= en_q[EN_PUMP] && en_q[EN_BIAS];
    end
  end

  // Whole loop bias
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      loop_enable <= 1'b0;
    end else begin
      loop_enable <= en_q[EN_BIAS];
    end
  end

  // Modulator clock source
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dsm_clk_from_vco <= 1'b0;
    end else begin
      dsm_clk_from_vco <= en_q[EN_VCOCLK];
    end
  end

  // Modulator reset, active low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dsm_rst_n <= 1'b0;
    end else begin
      dsm_rst_n <= en_q[EN_DSM];
    end
  end

  // Lock detection reset, active low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock_det_rst_n <= 1'b0;
    end else begin
      lock_det_rst_n <= en_q[EN_LOCK];
    end
  end

  // Slip prevention flip-flop reset, active low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slip_prevention_rst_n <= 1'b0;
    end else begin
      slip_prevention_rst_n <= en_q[EN_SLIP];
    end
  end

  // Digital lock detect and its output gates
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock_gate_en <= 1'b0;
    end else begin
      lock_gate_en <= en_q[EN_LKD];
    end
  end
endmodule // scb_synth_control_register_bank
`default_nettype wire

// >>> verif/scb_checker.sv
`timescale 1ns/1ns
`default_nettype none
module scb_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] block_enable_and_reset,
  input wire logic loop_enable,
  input wire logic pump_enable,
  input wire logic dsm_clk_from_vco,
  input wire logic dsm_rst_n,
  input wire logic lock_det_rst_n,
  input wire logic slip_prevention_rst_n,
  input wire logic lock_gate_en,
  input wire logic ref_div_run,
  input wire logic square_buffer_on,
  input wire logic sine_buffer_on,
  input wire logic sine_ref_select,
  input wire logic soft_reset_dig,
  input wire logic temp_measure_start
);
  wire logic [15:0] en = block_enable_and_reset;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Enable register unchanged over three samples
  sequence en_steady;
    $stable(en) [*2];
  endsequence
  a_loop_bias: assert property (en_steady |-> loop_enable == en[1])
    else $error("loop enable wrong");
  a_pump_gate: assert property (en_steady |-> pump_enable == (en[12] & en[1]))
    else $error("pump enable wrong");
  a_dsm_clock: assert property (en_steady |-> dsm_clk_from_vco == en[9])
    else $error("modulator clock select wrong");
  a_block_resets: assert property (en_steady |->
    {dsm_rst_n, lock_det_rst_n, slip_prevention_rst_n} == {en[13], en[14], en[15]})
    else $error("block reset wrong");
  a_lock_gate: assert property (en_steady |-> lock_gate_en == en[11])
    else $error("lock gate wrong");
  a_div_run: assert property (en_steady |-> ref_div_run == en[2])
    else $error("divider run wrong");
  a_buf_select: assert property (!(square_buffer_on && sine_ref_select) &&
    !(sine_buffer_on && !sine_ref_select)) else $error("buffer against select");
  a_dig_pulse: assert property (soft_reset_dig |=> !soft_reset_dig)
    else $error("soft reset pulse too long");
  a_temp_pulse: assert property (temp_measure_start |=> !temp_measure_start)
    else $error("temp start pulse too long");
endmodule // scb_checker
bind scb_synth_control_register_bank scb_checker u_chk (.mclk, .arst_n, .block_enable_and_reset,
  .loop_enable, .pump_enable, .dsm_clk_from_vco, .dsm_rst_n, .lock_det_rst_n,
  .slip_prevention_rst_n, .lock_gate_en, .ref_div_run, .square_buffer_on, .sine_buffer_on,
  .sine_ref_select, .soft_reset_dig, .temp_measure_start);
`default_nettype wire

// >>> verif/scb_host.sv
`timescale 1ns/1ns
`default_nettype none
module scb_host (
  input wire logic mclk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic sclk,
  output logic sen,
  output logic sdi
);
  // Serial clock parked low outside frames
  initial begin
    sclk = 1'b0;
    sen = 1'b0;
    sdi = 1'b0;
  end
  // One frame: flag, six address bits, 24 data bits, MSB first
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q, output logic oe_rd);
    logic [31:0] w;
    w = {rd, a, d, 1'b0};
    q = 24'h0;
    oe_rd = 1'b1;
    @(negedge mclk);
    sen = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      sdi = w[i];
      repeat (4) @(negedge mclk);
      sclk = 1'b1;
      repeat (4) @(negedge mclk);
      if (rd && i >= 1 && i <= 24) begin
        q[i-1] = pin_oe ? pin_o : 1'bx;
        oe_rd = oe_rd & pin_oe;
      end
      sclk = 1'b0;
      @(negedge mclk);
    end
    sen = 1'b0;
    sdi = ~sdi;
    repeat (6) @(negedge mclk);
  endtask
endmodule // scb_host
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import scb_pkg::*;
  logic mclk, arst_n, sclk, sen, sdi, lock_status, pin_o, pin_oe, bypass, oe_rd;
  logic dig, temp, pfd_invert, pfd_up_pass, pfd_dn_pass, long_low, sine_sel;
  logic [15:0] ber;
  logic [13:0] ratio;
  logic [2:0] pfd_delay;
  logic [23:0] m[0:7];
  logic [23:0] q;
  int wd[0:7] = '{0, 16, 2, 17, 1, 3, 3, 0};
  int errors, n_compared, cyc, n_dig, n_temp;
  scb_synth_control_register_bank u_scb_synth_control_register_bank (
    .mclk(mclk), .arst_n(arst_n), .sclk_pin(sclk), .sen_pin(sen), .sdi_pin(sdi),
    .lock_status(lock_status), .lock_or_readback_pin_o(pin_o),
    .lock_or_readback_pin_oe(pin_oe), .block_enable_and_reset(ber), .ref_div_ratio(ratio),
    .ref_div_run(), .ref_div_bypass(bypass), .sine_ref_select(sine_sel),
    .square_buffer_on(), .sine_buffer_on(), .prescaler_long_low(long_low),
    .pfd_invert(pfd_invert), .pfd_up_pass(pfd_up_pass), .pfd_dn_pass(pfd_dn_pass),
    .pfd_delay(pfd_delay), .pump_enable(), .loop_enable(), .dsm_clk_from_vco(),
    .dsm_rst_n(), .lock_det_rst_n(), .slip_prevention_rst_n(), .lock_gate_en(),
    .soft_reset_dig(dig), .temp_measure_start(temp));
  scb_host u_host (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .sclk(sclk), .sen(sen),
    .sdi(sdi));
  // Clock and cycle watchdog, strobe pulse counters
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (dig === 1'b1) n_dig++;
    if (temp === 1'b1) n_temp++;
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic void defaults();
    m = '{ID_WORD, 24'(RST_EN), 24'(RST_DRV), 24'(RST_REF), 24'(RST_PRE), 24'(RST_PFD),
      24'(RST_DEL), 24'h0};
  endfunction
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    u_host.xfer(1'b0, a, d, q, oe_rd);
    if (a == ADDR_ID && d[STB_REGS]) defaults();
    else if (a != ADDR_ID && a <= ADDR_DEL) m[a[2:0]] = d & ((24'h1 << wd[a[2:0]]) - 24'h1);
  endtask
  task automatic rd_all();
    for (int a = 0; a < 8; a++) begin
      u_host.xfer(1'b1, 6'(a), 24'h0, q, oe_rd);
      chk(q, m[a]);
    end
  endtask
  task automatic outs();
    chk(24'(ber), m[1]);
    chk(24'(ratio), m[3] & 24'h3FFF);
    chk(24'(bypass), 24'(!m[1][EN_DIV] || (m[3][REF_AUTO] ? m[3][13:0] == RATIO_ONE
      : !m[3][REF_SEL])));
    chk(24'(sine_sel), 24'(m[3][16]));
    chk(24'(long_low), m[4]);
    chk(24'({pfd_dn_pass, pfd_up_pass, pfd_invert}), m[5]);
    chk(24'(pfd_delay), m[6]);
  endtask
  // Main sequence
  initial begin
    arst_n = 1'b0;
    void'($urandom(32'h881A));
    lock_status = 1'($urandom);
    defaults();
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk(24'(pin_oe ? pin_o : 1'bx), 24'(lock_status));
    outs();
    rd_all();
    repeat (3) begin
      for (int a = 1; a < 8; a++)
        wr(6'(a), 24'($urandom) | (a == 2 ? 24'h1 : 24'h0) | (a == 3 ? 24'h2 : 24'h0));
      outs();
      rd_all();
    end
    wr(ADDR_ID, 24'h00000E);
    wr(ADDR_ID, 24'h000008);
    chk(24'(n_dig), 24'h1);
    chk(24'(n_temp), 24'h2);
    wr(ADDR_ID, 24'h000001);
    outs();
    rd_all();
    wr(ADDR_DRV, 24'h0);
    u_host.xfer(1'b1, ADDR_DRV, 24'h0, q, oe_rd);
    chk(24'(oe_rd), 24'h1);
    chk(q, m[2]);
    chk(24'(pin_oe), 24'h0);
    wr(ADDR_DRV, 24'h2);
    chk(24'(pin_oe), 24'h0);
    wr(ADDR_DRV, 24'h3);
    chk(24'(pin_oe), 24'h1);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
